/* File: include/sysref_align_pkg.sv */
// Constants shared by the frame/multi-frame alignment logic.
// Assumes a single mclk domain; all inputs synchronous except the sync pin.
package sysref_align_pkg;
   // =========================================================
   // Framing defaults
   localparam int unsigned FRAMES_PER_MF = 20;
   localparam int unsigned CLKS_PER_FRAME = 1;
   localparam int unsigned MIN_PULSE_FRAMES = 2;
   localparam int unsigned DRIFT_FRAMES = 2;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
endpackage : sysref_align_pkg

/* File: rtl/edge_gate.sv */
// SYSREF detection gate and rising-edge detector.
// Assumes sysref is already sampled on the undivided input clock.
module edge_gate (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Inputs
   input wire logic sysref,
   input wire logic gate_en,
   // Output
   output logic rise
);
   typedef struct packed {
      logic prev;
   } state_s;
   state_s st_r;
   state_s st_nxt;
   logic gated;

   // Gate opened on a high level looks like an edge, as the hardware does
   assign gated = sysref & gate_en;
   assign rise = gated & ~st_r.prev;

   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = gated;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{prev: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : edge_gate

/* File: rtl/sync_stage.sv */
// Two-flop synchroniser for the asynchronous sync request pin.
// Assumes the input may change at any time relative to mclk.
module sync_stage (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } state_s;
   state_s st_r;
   state_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = async_in;
      st_nxt.stable = st_r.meta;
   end

   // Idle high: no request while in reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{meta: 1'b1, stable: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stable;
endmodule : sync_stage

/* File: rtl/sysref_lmfc_alignment_sync.sv */
// Frame clock and LMFC phase alignment from SYSREF, plus link break
// on misaligned SYSREF or receiver sync request.
// Assumes mclk is the undivided input clock and sysref is synchronous to it.
module sysref_lmfc_alignment_sync #(
   parameter int unsigned K = sysref_align_pkg::FRAMES_PER_MF,
   parameter int unsigned FRAME_CLKS = sysref_align_pkg::CLKS_PER_FRAME
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // SYSREF path
   input wire logic sysref,
   input wire logic sysref_gate_en,
   // Synchronisation request
   input wire logic sync_request_pin_n,
   input wire logic sync_sel,
   input wire logic sync_reg_n,
   // Internal clocks and link state
   output logic frame_tick,
   output logic lmfc_tick,
   output logic aligned,
   output logic link_break,
   output logic sync_req
);
   localparam int unsigned W = sysref_align_pkg::CNT_W;

   typedef struct packed {
      logic [W-1:0] fcnt;
      logic [W-1:0] mcnt;
      logic aligned;
      logic brk;
      logic ftick;
      logic mtick;
      logic sreq;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   logic rise;
   logic pin_sync;
   logic req_n;
   logic on_grid;

   // Wrap test used for both counters
   function automatic logic at_last(input logic [W-1:0] c,
                                    input int unsigned n);
      at_last = (c == W'(n - 1));
   endfunction : at_last

   // =========================================================
   // Input conditioning
   edge_gate u_gate (
      .mclk(mclk),
      .reset_n(reset_n),
      .sysref(sysref),
      .gate_en(sysref_gate_en),
      .rise(rise)
   );

   sync_stage u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in(sync_request_pin_n),
      .sync_out(pin_sync)
   );

   // Register source overrides the pin, which may float
   assign req_n = sync_sel ? sync_reg_n : pin_sync;

   // Edge is on grid when counters sit at multi-frame start
   assign on_grid = (st_r.fcnt == sysref_align_pkg::CNT_ZERO) &&
                    (st_r.mcnt == sysref_align_pkg::CNT_ZERO);

   // =========================================================
   // Phase counters and alignment decision
   always_comb begin
      st_nxt = st_r;
      st_nxt.brk = 1'b0;
      st_nxt.ftick = 1'b0;
      st_nxt.mtick = 1'b0;
      st_nxt.sreq = ~req_n;
      if (at_last(st_r.fcnt, FRAME_CLKS)) begin
         st_nxt.fcnt = sysref_align_pkg::CNT_ZERO;
         st_nxt.ftick = 1'b1;
         if (at_last(st_r.mcnt, K)) begin
            st_nxt.mcnt = sysref_align_pkg::CNT_ZERO;
            st_nxt.mtick = 1'b1;
         end else begin
            st_nxt.mcnt = st_r.mcnt + W'(1);
         end
      end else begin
         st_nxt.fcnt = st_r.fcnt + W'(1);
      end
      if (rise) begin
         if (st_r.aligned && on_grid) begin
            // Phase already right: nothing changes
            st_nxt.aligned = 1'b1;
         end else begin
            // Restart both counters so the edge is the new phase zero
            st_nxt.fcnt = (FRAME_CLKS > 1) ? W'(1)
                          : sysref_align_pkg::CNT_ZERO;
            st_nxt.mcnt = (FRAME_CLKS > 1) ? sysref_align_pkg::CNT_ZERO
                          : ((K > 1) ? W'(1)
                             : sysref_align_pkg::CNT_ZERO);
            st_nxt.aligned = 1'b1;
            st_nxt.brk = 1'b1;
            st_nxt.ftick = 1'b0;
            st_nxt.mtick = 1'b0;
         end
      end
      if (!req_n) begin
         st_nxt.brk = 1'b1;
      end
   end

   // Limitation: phase is resolved only to one mclk, the undivided clock
   // Without SYSREF the power-up phase stands, up to one multi-frame
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign frame_tick = st_r.ftick;
   assign lmfc_tick = st_r.mtick;
   assign aligned = st_r.aligned;
   assign link_break = st_r.brk;
   assign sync_req = st_r.sreq;

   // =========================================================
   // Checks
   realign_zero_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && !(st_r.aligned && on_grid)) |=> link_break && aligned)
      else $error("misaligned edge did not break link");

   keep_phase_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && st_r.aligned && on_grid && req_n) |=> !link_break)
      else $error("aligned edge broke link");

   first_edge_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && !st_r.aligned) |=> link_break)
      else $error("first edge did not align");

   sync_break_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!req_n) |=> link_break && sync_req)
      else $error("sync request did not break link");

   sync_sel_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (sync_sel && sync_reg_n && !rise) |=> !sync_req)
      else $error("pin used while register source selected");

   gate_and_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !sysref_gate_en |-> !rise)
      else $error("edge seen with gate closed");

   gate_open_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (sysref && $rose(sysref_gate_en) && !(st_r.aligned && on_grid))
      |=> link_break)
      else $error("gate opening on high level missed");

   pin_delay_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!sync_sel && $fell(sync_request_pin_n)) ##1 !sync_request_pin_n
      |=> !pin_sync)
      else $error("sync pin synchroniser depth wrong");

   lmfc_period_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      lmfc_tick |-> frame_tick)
      else $error("lmfc tick off a frame boundary");

   // =========================================================
   // Phase counter checks
   // Counters must never leave their ranges, or the grid test is blind
   fcnt_range_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      st_r.fcnt < W'(FRAME_CLKS))
      else $error("frame counter out of range");

   mcnt_range_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      st_r.mcnt < W'(K))
      else $error("multi-frame counter out of range");

   frame_wrap_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!rise && at_last(st_r.fcnt, FRAME_CLKS)) |=> frame_tick)
      else $error("frame tick missing at wrap");

   lmfc_wrap_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!rise && at_last(st_r.fcnt, FRAME_CLKS) && at_last(st_r.mcnt, K))
      |=> lmfc_tick && (st_r.mcnt == sysref_align_pkg::CNT_ZERO))
      else $error("lmfc tick missing at wrap");

   lmfc_mid_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !(at_last(st_r.fcnt, FRAME_CLKS) && at_last(st_r.mcnt, K))
      |=> !lmfc_tick)
      else $error("lmfc tick inside a multi-frame");

   single_rise_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      rise |=> !rise)
      else $error("edge detector fired twice");

   // =========================================================
   // Alignment checks
   // A re-phase restarts at phase zero, so no tick may follow at once
   realign_quiet_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && !(st_r.aligned && on_grid)) |=> !lmfc_tick && !frame_tick)
      else $error("tick right after re-phase");

   realign_start_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && !(st_r.aligned && on_grid))
      |=> (st_r.mcnt <= W'(1)) && (st_r.fcnt <= W'(1)))
      else $error("re-phase did not restart counters");

   aligned_sticky_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      aligned |=> aligned)
      else $error("alignment lost");

   keep_aligned_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (rise && st_r.aligned && on_grid) |=> aligned)
      else $error("on-grid edge dropped alignment");

   quiet_link_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (aligned && !rise && req_n) |=> !link_break)
      else $error("link broken without cause");

   closed_gate_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!sysref_gate_en && req_n) |=> !link_break)
      else $error("break with gate closed");

   // =========================================================
   // Link break and sync request checks
   // Every break must trace back to an edge or a request a cycle earlier
   break_cause_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      link_break |-> ($past(rise) || !$past(req_n)))
      else $error("break with no cause");

   sync_idle_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      req_n |=> !sync_req)
      else $error("sync request without low level");

   reg_request_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (sync_sel && !sync_reg_n) |=> sync_req && link_break)
      else $error("register request not taken");

   pin_held_a: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!sync_sel && !pin_sync) |=> sync_req)
      else $error("synchronised pin request lost");
endmodule : sysref_lmfc_alignment_sync

/* File: verification/sysref_lmfc_alignment_sync_tb.sv */
// Self-checking bench for the SYSREF frame/LMFC alignment block.
// Assumes K frames of one mclk each; partner model drives the far side.
module sysref_lmfc_alignment_sync_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int K = sysref_align_pkg::FRAMES_PER_MF;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic sysref, sync_request_pin_n;
   logic sysref_gate_en = 1'b0;
   logic sync_sel = 1'b0;
   logic sync_reg_n = 1'b1;
   logic frame_tick, lmfc_tick, aligned, link_break, sync_req;
   int miscompares = 0;
   int samples_checked = 0;
   int breaks = 0;
   int ticks = 0;
   int b0, t0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      if (link_break === 1'b1) breaks++;
      if (lmfc_tick === 1'b1) ticks++;
   end
   sysref_lmfc_alignment_sync i_sysref_lmfc_alignment_sync (
      .mclk(mclk), .reset_n(reset_n), .sysref(sysref),
      .sysref_gate_en(sysref_gate_en),
      .sync_request_pin_n(sync_request_pin_n), .sync_sel(sync_sel),
      .sync_reg_n(sync_reg_n), .frame_tick(frame_tick),
      .lmfc_tick(lmfc_tick), .aligned(aligned), .link_break(link_break),
      .sync_req(sync_req));
   sysref_source i_sysref_source (
      .mclk(mclk), .sysref(sysref), .sync_request_pin_n(sync_request_pin_n));
   // =========================================
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic check_bit(input logic got, input logic exp, input string s);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s", $time, s);
      end
   endtask : check_bit
   task automatic check_cnt(input int got, input int exp, input string s);
      samples_checked++;
      if (got != exp) begin
         miscompares++;
         $display("ERROR %0t %s count %0d", $time, s, got);
      end
   endtask : check_cnt
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   // =========================================
   task automatic test_first_edge;
      check_bit(aligned, 1'b0, "aligned out of reset");
      sysref_gate_en = 1'b1;
      step(3);
      b0 = breaks;
      i_sysref_source.burst(1, K, 2);
      check_bit(aligned, 1'b1, "first edge");
      check_cnt(breaks - b0, 1, "first edge breaks");
      t0 = ticks;
      step(4 * K);
      check_cnt(ticks - t0, 4, "lmfc period");
      $display("test first_edge done");
   endtask : test_first_edge
   task automatic test_on_grid;
      for (int n = 1; n <= 2; n++) begin
         i_sysref_source.burst(1, n * K, 4);
         b0 = breaks;
         i_sysref_source.burst(3, n * K, 4);
         check_cnt(breaks - b0, 0, "on-grid edges");
      end
      $display("test on_grid done");
   endtask : test_on_grid
   task automatic test_off_grid;
      // Spacing of K + 3 puts even the first counted edge off the grid
      i_sysref_source.burst(1, K + 3, 4);
      b0 = breaks;
      i_sysref_source.burst(3, K + 3, 4);
      check_cnt(breaks - b0, 3, "off-grid edges");
      check_bit(aligned, 1'b1, "aligned kept");
      $display("test off_grid done");
   endtask : test_off_grid
   task automatic test_gate;
      sysref_gate_en = 1'b0;
      step(2);
      i_sysref_source.level(1'b1);
      b0 = breaks;
      step(6);
      check_cnt(breaks - b0, 0, "closed gate");
      sysref_gate_en = 1'b1;
      step(4);
      check_cnt(breaks - b0, 1, "false edge");
      i_sysref_source.level(1'b0);
      step(7);
      i_sysref_source.burst(1, K, 4);
      check_cnt(breaks - b0, 2, "edge after false one");
      sysref_gate_en = 1'b0; // Closed after the source has gone idle
      $display("test gate done");
   endtask : test_gate
   task automatic test_sync;
      i_sysref_source.request(1'b0);
      step(1);
      check_bit(sync_req, 1'b0, "pin not yet through");
      step(4);
      check_bit(sync_req, 1'b1, "pin request");
      check_bit(link_break, 1'b1, "pin break");
      i_sysref_source.request(1'b1);
      step(6);
      check_bit(sync_req, 1'b0, "pin released");
      sync_sel = 1'b1;
      i_sysref_source.request(1'b0);
      step(6);
      check_bit(sync_req, 1'b0, "pin ignored");
      sync_reg_n = 1'b0;
      step(3);
      check_bit(sync_req, 1'b1, "register request");
      check_bit(link_break, 1'b1, "register break");
      sync_reg_n = 1'b1;
      i_sysref_source.request(1'b1);
      step(3);
      check_bit(sync_req, 1'b0, "register released");
      $display("test sync done");
   endtask : test_sync
   // =========================================
   initial begin
      repeat (6) @(posedge mclk);
      #1 reset_n = 1'b1;
      step(1);
      test_first_edge();
      test_on_grid();
      test_off_grid();
      test_gate();
      test_sync();
      test_done();
   end
   // Tests need about 500 cycles; allow far more
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      test_done();
   end
endmodule : sysref_lmfc_alignment_sync_tb

/* File: verification/sysref_source.sv */
// Far-side model: SYSREF generator and JESD204B receiver sync pin.
// Assumes callers enter its tasks just after a rising edge of mclk.
module sysref_source (
   // Clock
   input wire logic mclk,
   // Far-side lines
   output logic sysref,
   output logic sync_request_pin_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle: no SYSREF, no request; idle-zero level needs no offset
   initial begin
      sysref = 1'b0;
      sync_request_pin_n = 1'b1;
   end
   // =========================================
   // SYSREF edges are launched off mclk, so they meet its setup
   task automatic burst(input int n, input int gap, input int high);
      for (int i = 0; i < n; i++) begin
         sysref = 1'b1;
         repeat (high) @(posedge mclk); // Two frames or more
         #1 sysref = 1'b0;
         repeat (gap - high) @(posedge mclk); // Multi-frame grid
         #1;
      end
   endtask : burst
   task automatic level(input logic v);
      sysref = v;
   endtask : level
   // Odd offset: the request has no phase relation to mclk
   task automatic request(input logic v);
      #2 sync_request_pin_n = v; // Low asks for sync
   endtask : request
endmodule : sysref_source
